// ==== trigger_routing_and_acq_start.sv ====
// Function pin routing, start/reference trigger sequencer and digital lines
`timescale 1ns/1ps
`include "trig_route_cfg.svh"

// Overview of operation
// RULE1 - Eight digital lines, each own direction
// RULE2 - External timing control only via ten pins
// RULE3 - Fixed signal per pin, five dedicated outputs
// RULE4 - Source select per thirteen internal signals
// RULE5 - Per-pin output driver enable
// RULE6 - Outside must not drive enabled pins
// RULE7 - Per-pin polarity, edge or level detection
// RULE8 - Edge inputs need 10 ns pulses; code samples every 20 ns, so pulses under 20 ns can be missed
// RULE9 - Level mode adds no width limits
// RULE10 - Start trigger selected edge begins acquisition
// RULE11 - Start output pulse 50 to 100 ns
// RULE12 - Trigger pins high impedance after power-up
// RULE13 - Software start trigger accepted
// RULE14 - Reference edge begins posttrigger phase
// RULE15 - Count pretrigger scans, then reload posttrigger
// RULE16 - Reference ignored before pretrigger count ends
// RULE17 - Acquire posttrigger scans, then stop
// RULE18 - Reference output pulse 50 to 100 ns
// RULE19 - Posttriggered mode ignores reference trigger
// RULE20 - Start trigger runs internal scan-start counter
// RULE21 - Two-stage synchroniser before detection
module trigger_routing_and_acq_start
  import trig_route_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input  wire logic                      clock_i,
  input  wire logic                      nrst_i,
  input  wire logic [7:0]                addr_i,
  input  wire logic [31:0]               wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [31:0]               rdata_o,
  input  wire logic [`NUM_PFI-1:0]       pfi_i,
  output logic      [`NUM_PFI-1:0]       pfi_o,
  output logic      [`NUM_PFI-1:0]       pfi_oe_o,
  input  wire logic [`NUM_PFI-1:0]       fixed_timing_i,
  input  wire logic [`NUM_DEDICATED-1:0] dedicated_src_i,
  output logic      [`NUM_DEDICATED-1:0] dedicated_o,
  output logic      [`NUM_SIG-1:0]       timing_o,
  output logic                           scan_start_o,
  output logic                           acq_active_o,
  input  wire logic [`NUM_DIO-1:0]       dio_i,
  output logic      [`NUM_DIO-1:0]       dio_o,
  output logic      [`NUM_DIO-1:0]       dio_oe_o
);

  // ========================================================================
  // Declarations
  seq_state_type             state_q;
  logic                      pretrig_q;
  logic [CNT_W-1:0]          pre_q;
  logic [CNT_W-1:0]          post_q;
  logic [CNT_W-1:0]          period_q;
  logic [CNT_W-1:0]          period_cnt_q;
  logic [CNT_W-1:0]          scan_cnt_q;
  logic [`NUM_PFI-1:0]       pfi_oe_q;
  logic [`NUM_PFI-1:0]       pfi_pol_q;
  logic [`NUM_PFI-1:0]       pfi_lvl_q;
  logic [`NUM_PFI-1:0]       pfi_q;
  logic [`NUM_PFI-1:0]       pfi_d;
  logic [`NUM_DIO-1:0]       dio_dir_q;
  logic [`NUM_DIO-1:0]       dio_out_q;
  logic [`NUM_DEDICATED-1:0] dedicated_q;
  pin_sel_type               src_q [`NUM_SIG];
  logic [`NUM_PFI-1:0]       pin_level;
  logic [`NUM_PFI-1:0]       pin_edge;
  logic [`NUM_SIG-1:0]       sig_edge;
  logic [`NUM_SIG-1:0]       timing_q;
  logic [2:0]                pulse_ev;
  logic [2:0]                pulse_on;
  logic [2:0]                pulse_cnt_q [3];
  logic                      done_q;
  logic                      ref_seen_q;
  logic                      scan_start_q;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  logic [7:0]                src_off;
  logic [3:0]                src_idx;
  logic                      src_hit;
  logic                      ctrl_wr;
  logic                      sw_start;
  logic                      sw_stop;
  logic                      acq_run;
  logic                      ext_scan;
  logic                      scan_evt;
  logic                      start_accept;
  logic                      ref_accept;
  logic                      acq_end;

  // ========================================================================
  // Pin conditioning
  for (genvar p = 0; p < `NUM_PFI; p++) begin : g_pin
    pin_conditioner u_cond (
      .clock_i  (clock_i),
      .nrst_i   (nrst_i),
      .pin_i    (pfi_i[p]),
      .invert_i (pfi_pol_q[p]),
      .level_o  (pin_level[p]),
      .edge_o   (pin_edge[p])
    );
  end

  // ========================================================================
  // Source selection per internal timing signal
  for (genvar s = 0; s < `NUM_SIG; s++) begin : g_sig
    logic sel_ok;
    assign sel_ok      = src_q[s] < 4'(`NUM_PFI);
    assign sig_edge[s] = sel_ok ? pin_edge[src_q[s]] : 1'b0; // see RULE2

    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        timing_q[s] <= 1'b0;
      end else if (!sel_ok) begin
        timing_q[s] <= 1'b0;
      end else if (pfi_lvl_q[src_q[s]]) begin
        timing_q[s] <= pin_level[src_q[s]]; // see RULE9
      end else begin
        timing_q[s] <= pin_edge[src_q[s]];  // see RULE4
      end
    end
  end

  assign timing_o = timing_q;

  // ========================================================================
  // Register access
  assign src_off  = addr_i - `OFS_SRC_BASE;
  assign src_idx  = src_off[5:2];
  assign src_hit  = (addr_i[1:0] == 2'b00) && (addr_i >= `OFS_SRC_BASE)
                    && (src_off[7:2] < 6'(`NUM_SIG));
  assign ctrl_wr  = wr_i && (addr_i == `OFS_CTRL);
  assign sw_start = ctrl_wr && wdata_i[`CTRL_START_BIT];
  assign sw_stop  = ctrl_wr && wdata_i[`CTRL_STOP_BIT];

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pretrig_q <= 1'b0;
      pre_q     <= CNT_W'(`PRE_CNT_RST);
      post_q    <= CNT_W'(`POST_CNT_RST);
      period_q  <= CNT_W'(`SCAN_PERIOD_RST);
      pfi_oe_q  <= '0;
      pfi_pol_q <= '0;
      pfi_lvl_q <= '0;
      dio_dir_q <= '0;
      dio_out_q <= '0;
    end else if (wr_i) begin
      unique case (addr_i)
        `OFS_CTRL:        pretrig_q <= wdata_i[`CTRL_PRETRIG_BIT];
        `OFS_PRE_CNT:     pre_q     <= wdata_i[CNT_W-1:0];
        `OFS_POST_CNT:    post_q    <= wdata_i[CNT_W-1:0];
        `OFS_SCAN_PERIOD: period_q  <= wdata_i[CNT_W-1:0];
        `OFS_PFI_OE:      pfi_oe_q  <= wdata_i[`NUM_PFI-1:0]; // see RULE5
        `OFS_PFI_POL:     pfi_pol_q <= wdata_i[`NUM_PFI-1:0]; // see RULE7
        `OFS_PFI_LEVEL:   pfi_lvl_q <= wdata_i[`NUM_PFI-1:0]; // see RULE7
        `OFS_DIO_DIR:     dio_dir_q <= wdata_i[`NUM_DIO-1:0]; // see RULE1
        `OFS_DIO_OUT:     dio_out_q <= wdata_i[`NUM_DIO-1:0];
        default: ;
      endcase
    end
  end

  // Unselected signals take no pin
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < `NUM_SIG; i++) begin
        src_q[i] <= `SRC_NONE;
      end
    end else if (wr_i && src_hit) begin
      src_q[src_idx] <= wdata_i[3:0]; // see RULE4
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (addr_i)
      `OFS_CTRL:        rdata_d[`CTRL_PRETRIG_BIT] = pretrig_q;
      `OFS_STATUS: begin
        rdata_d[`STAT_BUSY_BIT]                     = acq_run;
        rdata_d[`STAT_STATE_LSB+2:`STAT_STATE_LSB]  = state_q;
        rdata_d[`STAT_REF_SEEN_BIT]                 = ref_seen_q;
        rdata_d[`STAT_DONE_BIT]                     = done_q;
      end
      `OFS_PRE_CNT:     rdata_d[CNT_W-1:0]    = pre_q;
      `OFS_POST_CNT:    rdata_d[CNT_W-1:0]    = post_q;
      `OFS_SCAN_PERIOD: rdata_d[CNT_W-1:0]    = period_q;
      `OFS_PFI_OE:      rdata_d[`NUM_PFI-1:0] = pfi_oe_q;
      `OFS_PFI_POL:     rdata_d[`NUM_PFI-1:0] = pfi_pol_q;
      `OFS_PFI_LEVEL:   rdata_d[`NUM_PFI-1:0] = pfi_lvl_q;
      `OFS_DIO_DIR:     rdata_d[`NUM_DIO-1:0] = dio_dir_q;
      `OFS_DIO_OUT:     rdata_d[`NUM_DIO-1:0] = dio_out_q;
      `OFS_DIO_IN:      rdata_d[`NUM_DIO-1:0] = dio_i;
      `OFS_SCAN_COUNT:  rdata_d[CNT_W-1:0]    = scan_cnt_q;
      default: begin
        if (src_hit) begin
          rdata_d[3:0] = src_q[src_idx];
        end
      end
    endcase
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_i ? rdata_d : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_q;

  // ========================================================================
  // Scan-start generation
  assign acq_run  = (state_q != ST_IDLE);
  assign ext_scan = (src_q[`SIG_SCAN] < 4'(`NUM_PFI));
  // Scans outside an acquisition are dropped
  assign scan_evt = acq_run && (ext_scan ? sig_edge[`SIG_SCAN]
                                         : (period_cnt_q == '0)); // see RULE20

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      period_cnt_q <= '0;
    end else if (start_accept) begin
      period_cnt_q <= period_q; // see RULE20
    end else if (acq_run && !ext_scan) begin
      period_cnt_q <= (period_cnt_q == '0) ? period_q : period_cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_start_q <= 1'b0;
    end else begin
      scan_start_q <= scan_evt;
    end
  end

  assign scan_start_o = scan_start_q;

  // ========================================================================
  // Acquisition sequencer
  assign start_accept = (state_q == ST_IDLE) && !sw_stop
                        && (sig_edge[`SIG_START] || sw_start); // see RULE10 see RULE13
  assign ref_accept   = (state_q == ST_ARMED) && !sw_stop
                        && sig_edge[`SIG_REF];                 // see RULE14 see RULE16
  assign acq_end      = (state_q == ST_POST) && !sw_stop
                        && ((scan_cnt_q == '0) || (scan_evt && scan_cnt_q == CNT_W'(1)));

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q    <= ST_IDLE;
      scan_cnt_q <= '0;
    end else if (sw_stop) begin
      state_q    <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_accept) begin
            if (!pretrig_q) begin
              state_q    <= ST_POST; // see RULE19
              scan_cnt_q <= post_q;
            end else if (pre_q == '0) begin
              state_q    <= ST_ARMED;
              scan_cnt_q <= post_q;
            end else begin
              state_q    <= ST_PRE;
              scan_cnt_q <= pre_q;   // see RULE15
            end
          end
        end
        ST_PRE: begin
          if (scan_evt) begin
            if (scan_cnt_q <= CNT_W'(1)) begin
              state_q    <= ST_ARMED;
              scan_cnt_q <= post_q;  // see RULE15
            end else begin
              scan_cnt_q <= scan_cnt_q - CNT_W'(1);
            end
          end
        end
        ST_ARMED: begin
          // Counter holds until the reference edge arrives
          if (ref_accept) begin
            state_q <= ST_POST;
          end
        end
        ST_POST: begin
          if (acq_end) begin
            state_q    <= ST_IDLE;   // see RULE17
            scan_cnt_q <= '0;
          end else if (scan_evt) begin
            scan_cnt_q <= scan_cnt_q - CNT_W'(1);
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign acq_active_o = acq_run;

  // Status flags cleared by the next accepted start
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_q     <= 1'b0;
      ref_seen_q <= 1'b0;
    end else begin
      if (acq_end) begin
        done_q <= 1'b1;
      end else if (start_accept) begin
        done_q <= 1'b0;
      end
      if (ref_accept) begin
        ref_seen_q <= 1'b1;
      end else if (start_accept) begin
        ref_seen_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Output pulse stretchers: start, reference, scan start
  assign pulse_ev = {scan_evt, ref_accept, start_accept};

  for (genvar k = 0; k < 3; k++) begin : g_pulse
    // A new event during a running pulse merges into it
    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        pulse_cnt_q[k] <= 3'h0;
      end else if (pulse_ev[k] && pulse_cnt_q[k] == 3'h0) begin
        pulse_cnt_q[k] <= 3'(`TRIG_PULSE_CYC); // see RULE11 see RULE18
      end else if (pulse_cnt_q[k] != 3'h0) begin
        pulse_cnt_q[k] <= pulse_cnt_q[k] - 3'h1;
      end
    end
    assign pulse_on[k] = (pulse_cnt_q[k] != 3'h0);
  end

  // ========================================================================
  // Pin, dedicated and digital line outputs
  always_comb begin
    pfi_d             = fixed_timing_i; // see RULE3
    pfi_d[`PIN_START] = pulse_on[0];    // see RULE11
    pfi_d[`PIN_REF]   = pulse_on[1];    // see RULE18
    pfi_d[`PIN_SCAN]  = pulse_on[2];
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pfi_q       <= '0;
      dedicated_q <= '0;
    end else begin
      pfi_q       <= pfi_d;
      dedicated_q <= dedicated_src_i;   // see RULE3
    end
  end

  // Drivers off at reset, so external sources see no contention
  assign pfi_o       = pfi_q;
  assign pfi_oe_o    = pfi_oe_q;        // see RULE5 see RULE6 see RULE12
  assign dedicated_o = dedicated_q;
  assign dio_o       = dio_out_q;
  assign dio_oe_o    = dio_dir_q;       // see RULE1

  // ========================================================================
  // Assertions
  oe_power_up_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE12
    !$past(nrst_i) |-> pfi_oe_o == '0)
    else $error("pin drivers enabled right after reset");

  start_pulse_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE11
    $rose(pfi_o[`PIN_START]) |-> pfi_o[`PIN_START] [*3] ##1 !pfi_o[`PIN_START])
    else $error("start pulse width not three cycles");

  ref_pulse_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE18
    ref_accept |-> ##2 pfi_o[`PIN_REF])
    else $error("reference pulse missing after accepted edge");

  sw_start_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE13
    (sw_start && !sw_stop && state_q == ST_IDLE) |-> ##2 pfi_o[`PIN_START])
    else $error("software start did not produce start pulse");

  start_edge_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE10
    (state_q == ST_IDLE && sig_edge[`SIG_START] && !sw_stop) |=> state_q != ST_IDLE)
    else $error("start edge did not begin acquisition");

  pre_reload_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE15
    (state_q == ST_PRE && scan_evt && scan_cnt_q == CNT_W'(1) && !sw_stop)
    |=> state_q == ST_ARMED && scan_cnt_q == $past(post_q))
    else $error("pretrigger count end did not reload");

  ref_ignored_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE16
    (state_q == ST_PRE && sig_edge[`SIG_REF]) |=> state_q != ST_POST && !ref_seen_q)
    else $error("reference accepted before pretrigger count ended");

  post_stop_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE17
    (state_q == ST_POST && scan_evt && scan_cnt_q == CNT_W'(1) && !sw_stop)
    |=> state_q == ST_IDLE && done_q)
    else $error("acquisition did not stop after last scan");

  posttrig_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE19
    (start_accept && !pretrig_q) |=> state_q == ST_POST && !ref_seen_q)
    else $error("posttriggered start did not go to post phase");

  scan_gate_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE20
    scan_start_o |-> $past(state_q) != ST_IDLE)
    else $error("scan start outside an acquisition");

endmodule

// ==== trig_route_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the trigger block
`ifndef TRIG_ROUTE_CFG_SVH
`define TRIG_ROUTE_CFG_SVH

// ==========================================================================
// Sizes and fixed routing
`define NUM_PFI            10
`define NUM_DIO            8
`define NUM_SIG            13
`define NUM_DEDICATED      5
`define SIG_START          0
`define SIG_REF            1
`define SIG_SCAN           2
`define PIN_START          0
`define PIN_REF            1
`define PIN_SCAN           7
`define SRC_NONE           4'hf

// ==========================================================================
// Register byte offsets
`define OFS_CTRL           8'h00
`define OFS_STATUS         8'h04
`define OFS_PRE_CNT        8'h08
`define OFS_POST_CNT       8'h0c
`define OFS_SCAN_PERIOD    8'h10
`define OFS_PFI_OE         8'h14
`define OFS_PFI_POL        8'h18
`define OFS_PFI_LEVEL      8'h1c
`define OFS_DIO_DIR        8'h20
`define OFS_DIO_OUT        8'h24
`define OFS_DIO_IN         8'h28
`define OFS_SCAN_COUNT     8'h2c
`define OFS_SRC_BASE       8'h40

// ==========================================================================
// Control and status fields
`define CTRL_PRETRIG_BIT   0
`define CTRL_START_BIT     1
`define CTRL_STOP_BIT      2
`define STAT_BUSY_BIT      0
`define STAT_STATE_LSB     1
`define STAT_REF_SEEN_BIT  4
`define STAT_DONE_BIT      5

// ==========================================================================
// Reset values
`define SCAN_PERIOD_RST    24'h00_0064
`define PRE_CNT_RST        24'h00_0000
`define POST_CNT_RST       24'h00_0001

// ==========================================================================
// Timing
`define CLK_PERIOD_NS      20
`define TRIG_PULSE_MIN_NS  50
`define TRIG_PULSE_MAX_NS  100
`define TRIG_PULSE_CYC     ((`TRIG_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== trig_route_pkg.sv ====
// Types shared by the trigger routing block
package trig_route_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PRE   = 3'b001,
    ST_ARMED = 3'b010,
    ST_POST  = 3'b011
  } seq_state_type;

  typedef logic [3:0] pin_sel_type;

endpackage

// ==== pin_conditioner.sv ====
// One function pin input: synchroniser, polarity and edge detection
`timescale 1ns/1ps

module pin_conditioner (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic pin_i,
  input  wire logic invert_i,
  output logic      level_o,
  output logic      edge_o
);

  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic edge_q;

  // ========================================================================
  // Synchroniser
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;   // see RULE21
      sync2_q <= sync1_q; // see RULE21
    end
  end

  // ========================================================================
  // Polarity and edge
  // Pulses shorter than a clock period can be missed at 50 MHz
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_q <= 1'b0;
      edge_q  <= 1'b0;
    end else begin
      level_q <= sync2_q ^ invert_i;                // see RULE7
      edge_q  <= (sync2_q ^ invert_i) & ~level_q;   // see RULE8
    end
  end

  assign level_o = level_q;
  assign edge_o  = edge_q;

  pin_edge_a: assert property (@(posedge clock_i) disable iff (!nrst_i) // see RULE21
    edge_o |-> level_o && !$past(level_o))
    else $error("edge pulse without a rising conditioned level");

endmodule

// ==== trig_source_model.sv ====
// Behavioural model of external trigger sources wired to the function pins
`timescale 1ns/1ps

module trig_source_model (
  input  wire logic       clock_i,
  input  wire logic [9:0] pfi_oe_i,
  output logic      [9:0] drive_o
);
  initial begin
    drive_o = 10'h000;
  end

  // ==========================================================
  // Pulses away from the rest level
  // Skips a pin whose driver the device has switched on when the pulse starts
  task automatic pulse(input int pin, input int n);
    if (pfi_oe_i[pin] !== 1'b1) begin
      @(posedge clock_i);
      drive_o[pin] <= ~drive_o[pin];
      repeat (n) @(posedge clock_i);
      drive_o[pin] <= ~drive_o[pin];
    end
  endtask

  task automatic rest(input int pin, input logic lvl);
    @(posedge clock_i);
    drive_o[pin] <= lvl;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the trigger routing block
`timescale 1ns/1ps
`include "trig_route_cfg.svh"

module tb_top;
  logic        clock_i         = 1'b0;
  logic        nrst_i          = 1'b0;
  logic [7:0]  addr_i          = 8'h00;
  logic [31:0] wdata_i         = 32'h0000_0000;
  logic        wr_i            = 1'b0;
  logic        rd_i            = 1'b0;
  logic [9:0]  fixed_timing_i  = 10'h000;
  logic [4:0]  dedicated_src_i = 5'h00;
  logic [7:0]  dio_i           = 8'h00;
  logic [31:0] rdata_o;
  logic [9:0]  pfi_o;
  logic [9:0]  pfi_oe_o;
  logic [9:0]  ext;
  logic [4:0]  dedicated_o;
  logic [12:0] timing_o;
  logic        scan_start_o;
  logic        acq_active_o;
  logic [7:0]  dio_o;
  logic [7:0]  dio_oe_o;
  logic [31:0] v;
  int          mismatches      = 0;
  int          samples_checked = 0;
  int          scans           = 0;
  int          w;
  int          n;
  // Pin level seen by both sides; device driver wins where enabled
  wire  [9:0]  pin_lvl = (pfi_oe_o & pfi_o) | (~pfi_oe_o & ext);

  trigger_routing_and_acq_start dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pfi_i(pin_lvl), .pfi_o(pfi_o),
    .pfi_oe_o(pfi_oe_o), .fixed_timing_i(fixed_timing_i),
    .dedicated_src_i(dedicated_src_i), .dedicated_o(dedicated_o),
    .timing_o(timing_o), .scan_start_o(scan_start_o), .acq_active_o(acq_active_o),
    .dio_i(dio_i), .dio_o(dio_o), .dio_oe_o(dio_oe_o));

  trig_source_model ext_src (.clock_i(clock_i), .pfi_oe_i(pfi_oe_o), .drive_o(ext));

  initial begin
    forever #10 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (scan_start_o === 1'b1) scans++;
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask

  // Pulse on a device-driven pin must fall within the allowed ns span
  task automatic width_chk(input int b);
    for (int i = 0; i < 60 && pfi_o[b] !== 1'b1; i++) tick(1);
    w = 0;
    while (pfi_o[b] === 1'b1 && w < 20) begin
      w++;
      tick(1);
    end
    chk(32'(w * `CLK_PERIOD_NS >= `TRIG_PULSE_MIN_NS &&
            w * `CLK_PERIOD_NS <= `TRIG_PULSE_MAX_NS), 32'h0000_0001);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 2000 && acq_active_o !== 1'b0; i++) tick(1);
    tick(3);
    chk({31'h0, acq_active_o}, 32'h0000_0000);
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, far above the few hundred cycles the tests need
  initial begin
    #400_000;
    mismatches++;
    print_verdict();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    tick(1);
    chk({22'h0, pfi_oe_o}, 32'h0000_0000);
    rchk(`OFS_PRE_CNT, 32'h0000_0000);
    rchk(`OFS_POST_CNT, 32'h0000_0001);
    rchk(`OFS_SCAN_PERIOD, 32'h0000_0064);
    for (int k = 0; k < `NUM_SIG; k++) rchk(8'(`OFS_SRC_BASE + 4 * k), 32'h0000_000f);
    rchk(8'h3c, 32'h0000_0000);
    wr(`OFS_DIO_DIR, 32'h0000_000f);
    wr(`OFS_DIO_OUT, 32'h0000_00a5);
    dio_i <= 8'h3c;
    tick(2);
    chk({16'h0, dio_oe_o, dio_o}, 32'h0000_0fa5);
    rchk(`OFS_DIO_IN, 32'h0000_003c);
    wr(`OFS_PFI_OE, 32'h0000_0007);
    fixed_timing_i  <= 10'h004;
    dedicated_src_i <= 5'h15;
    tick(3);
    chk({21'h0, pfi_oe_o, pfi_o[2]}, 32'h0000_000f);
    chk({27'h0, dedicated_o}, 32'h0000_0015);
    // Posttriggered run by software start; reference edge must be ignored
    wr(`OFS_SCAN_PERIOD, 32'h0000_0009);
    wr(`OFS_POST_CNT, 32'h0000_0002);
    wr(8'(`OFS_SRC_BASE + 4), 32'h0000_0004);
    scans = 0;
    wr(`OFS_CTRL, 32'h0000_0002);
    width_chk(0);
    ext_src.pulse(4, 1);
    wait_idle();
    chk(scans, 32'h0000_0002);
    rchk(`OFS_STATUS, 32'h0000_0020);
    // External start from another pin on its falling edge
    // Invert before routing, so the idle-high pin gives no false start
    ext_src.rest(3, 1'b1);
    wr(`OFS_PFI_POL, 32'h0000_0008);
    wr(`OFS_SRC_BASE, 32'h0000_0003);
    ext_src.pulse(3, 1);
    width_chk(0);
    wait_idle();
    // Level mode with inversion routed to signal 5
    wr(8'(`OFS_SRC_BASE + 20), 32'h0000_0006);
    wr(`OFS_PFI_LEVEL, 32'h0000_0040);
    wr(`OFS_PFI_POL, 32'h0000_0048);
    ext_src.rest(6, 1'b0);
    tick(4);
    chk({31'h0, timing_o[5]}, 32'h0000_0001);
    ext_src.rest(6, 1'b1);
    tick(4);
    chk({31'h0, timing_o[5]}, 32'h0000_0000);
    // Pretriggered run: early reference refused, later one accepted
    // Mode bit must be set before the start write that relies on it
    wr(`OFS_PRE_CNT, 32'h0000_0002);
    wr(`OFS_CTRL, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0003);
    ext_src.pulse(4, 1);
    tick(3);
    rchk(`OFS_STATUS, 32'h0000_0003);
    v = 32'h0000_0000;
    for (n = 0; n < 60 && v !== 32'h0000_0005; n++) rd(`OFS_STATUS, v);
    chk(v, 32'h0000_0005);
    rchk(`OFS_SCAN_COUNT, 32'h0000_0002);
    // Align the edge just after a scan so no scan precedes the accept
    for (n = 0; n < 60 && scan_start_o !== 1'b1; n++) tick(1);
    ext_src.pulse(4, 1);
    scans = 0;
    width_chk(1);
    wait_idle();
    chk(scans, 32'h0000_0002);
    rchk(`OFS_STATUS, 32'h0000_0030);
    print_verdict();
  end
endmodule
